// ---- rtl/mgo_params.svh ----
`ifndef MGO_PARAMS_SVH
`define MGO_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (byte offsets on the plain register port)
// ----------------------------------------------------------------------
`define MGO_ADDR_MASK_EN   4'h0
`define MGO_ADDR_MASK_VAL  4'h1
`define MGO_ADDR_DEAD      4'h2
`define MGO_ADDR_POL       4'h3
`define MGO_ADDR_CTRL      4'h4
`define MGO_ADDR_HALL      4'h5
`define MGO_ADDR_PINFUNC   4'h6
`define MGO_ADDR_DRV_STAT  4'h7
`define MGO_ADDR_HALL_STAT 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MGO_RST_CHAN 6'h00
`define MGO_RST_BYTE 8'h00
`define MGO_RST_CTRL 7'h00
`define MGO_RST_HALL 5'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MGO_DT_CLK_MSB 7
`define MGO_DT_CLK_LSB 6
`define MGO_DT_EN_BIT  5
`define MGO_DT_CNT_MSB 4
`define MGO_CTL_BRAKE   0
`define MGO_CTL_PROTECT 1
`define MGO_CTL_PMODE   2
`define MGO_CTL_SWMASK  3
`define MGO_CTL_PWM_EN  4
`define MGO_CTL_COMP_EN 5
`define MGO_CTL_OUT_EN  6
`define MGO_HALL_SOFT_MSB 2
`define MGO_HALL_SRC_BIT  3
`define MGO_HALL_SEL_BIT  4

// ----------------------------------------------------------------------
// drive patterns: channel 0/2/4 high sides, 1/3/5 low sides
// ----------------------------------------------------------------------
`define MGO_LOW_SIDES  6'h2A
`define MGO_HIGH_SIDES 6'h15
`define MGO_ALL_ON     6'h3F
`define MGO_ALL_OFF    6'h00

`endif

// ---- rtl/mgo_pkg.sv ----
package mgo_pkg;
  // six gate channels: a_high, a_low, b_high, b_low, c_high, c_low
  typedef logic [5:0] mgo_chan_t;
  typedef logic [7:0] mgo_byte_t;
  typedef logic [3:0] mgo_addr_t;
  typedef logic [2:0] mgo_hall_t;
  // dead-time counting clock choice
  typedef enum logic [1:0]
  {
    MGO_DT_DIV1 = 2'h0,
    MGO_DT_DIV2 = 2'h1,
    MGO_DT_DIV4 = 2'h2,
    MGO_DT_DIV8 = 2'h3
  } mgo_dtclk_t;
endpackage

// ---- rtl/mgo_dead_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module mgo_dead_chan #(
  parameter int CW = 5
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          din,
  input  wire logic          tick,
  input  wire logic          dt_en,
  input  wire logic [CW-1:0] dt_val,
  output logic               dout
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic          out;   // delayed drive
    logic          busy;  // dead time running
    logic [CW-1:0] cnt;   // ticks left, less one
  } mgo_dc_state_t;

  mgo_dc_state_t q;
  mgo_dc_state_t d;

  if (CW < 1)
  begin : g_bad
    $error("dead-time counter width must be at least one");
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (!dt_en)
    begin
      // insertion off: plain one-cycle pass
      d.out  = din;
      d.busy = 1'b0;
      d.cnt  = '0;
    end
    else if (!din)
    begin
      // falling edge goes straight through and cancels a pending rise
      d.out  = 1'b0;
      d.busy = 1'b0;
    end
    else if (!q.out && !q.busy)
    begin
      // rising edge seen: hold low and start the count
      d.busy = 1'b1;
      d.cnt  = dt_val;
    end
    else if (q.busy && tick)
    begin
      // value+1 ticks of the chosen clock before the rise shows
      if (q.cnt == '0)
      begin
        d.out  = 1'b1;
        d.busy = 1'b0;
      end
      else
      begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign dout = q.out;
endmodule
`default_nettype wire

// ---- rtl/mgo_gate_stage.sv ----
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mgo_params.svh"
module mgo_gate_stage #(
  parameter int DT_CW = 5
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire mgo_pkg::mgo_addr_t reg_addr,
  input  wire mgo_pkg::mgo_byte_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output mgo_pkg::mgo_byte_t     reg_rdata,
  input  wire mgo_pkg::mgo_chan_t pwm_gen_in,
  input  wire mgo_pkg::mgo_hall_t hall_pin_in,
  input  wire mgo_pkg::mgo_hall_t hall_alt_in,
  output mgo_pkg::mgo_hall_t     hall_dec_out,
  output logic                   gate_a_high,
  output logic                   gate_a_low,
  output logic                   gate_b_high,
  output logic                   gate_b_low,
  output logic                   gate_c_high,
  output logic                   gate_c_low,
  output logic                   gate_a_high_oe,
  output logic                   gate_a_low_oe,
  output logic                   gate_b_high_oe,
  output logic                   gate_b_low_oe,
  output logic                   gate_c_high_oe,
  output logic                   gate_c_low_oe
);
  import mgo_pkg::*;

  if (DT_CW != `MGO_DT_CNT_MSB + 1)
  begin : g_bad_cw
    $error("dead-time counter must match the register field");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    mgo_chan_t  mask_en;  // per-channel mask enable
    mgo_chan_t  mask_val; // per-channel mask data
    mgo_byte_t  dead_time_setup;      // dead-time setup
    mgo_chan_t  pol;      // per-pin inversion
    logic [6:0] ctrl;     // brake, protect, modes, enables
    logic [4:0] hall_cfg; // soft hall values and source selects
    mgo_chan_t  gpio;     // 1: pin given to general I/O
    logic [2:0] presc;    // dead clock prescaler
    logic [5:0] hs1;      // hall synchroniser, first stage
    logic [5:0] hs2;
    logic [5:0] hs3;
    logic [5:0] hst;      // hall levels accepted once stages agree
    mgo_hall_t  hall;     // value handed to the decoder
    mgo_chan_t  drv;      // drive after guard, before polarity
    mgo_chan_t  pin;      // pin level after polarity
    mgo_chan_t  oe;       // pin output enables
    mgo_byte_t  rdata;    // read answer, one cycle after strobe
  } mgo_top_state_t;

  mgo_top_state_t q;
  mgo_top_state_t d;

  // ------------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------------
  logic       brake_ctrl;
  logic       protect_on;
  logic       protect_mode_sel;
  logic       mask_mode_sel;
  logic       pwm_out_enable;
  logic       comp_pwm_en;
  logic       gate_out_en;
  logic       dead_time_enable;
  logic       hall_src_mode;
  logic       hall_sel;
  mgo_dtclk_t dead_clk_sel;
  logic [DT_CW-1:0] dead_count_val;
  mgo_hall_t  hall_decoder_data;

  assign brake_ctrl        = q.ctrl[`MGO_CTL_BRAKE];
  assign protect_on        = q.ctrl[`MGO_CTL_PROTECT];
  assign protect_mode_sel  = q.ctrl[`MGO_CTL_PMODE];
  assign mask_mode_sel     = q.ctrl[`MGO_CTL_SWMASK];
  assign pwm_out_enable    = q.ctrl[`MGO_CTL_PWM_EN];
  assign comp_pwm_en       = q.ctrl[`MGO_CTL_COMP_EN];
  assign gate_out_en       = q.ctrl[`MGO_CTL_OUT_EN];
  assign dead_time_enable  = q.dead_time_setup[`MGO_DT_EN_BIT];
  assign dead_clk_sel      = mgo_dtclk_t'(q.dead_time_setup[`MGO_DT_CLK_MSB:`MGO_DT_CLK_LSB]);
  assign dead_count_val    = q.dead_time_setup[`MGO_DT_CNT_MSB:0];
  assign hall_decoder_data = q.hall_cfg[`MGO_HALL_SOFT_MSB:0];
  assign hall_src_mode     = q.hall_cfg[`MGO_HALL_SRC_BIT];
  assign hall_sel          = q.hall_cfg[`MGO_HALL_SEL_BIT];

  // ------------------------------------------------------------------
  // stage 1: masking, then brake / protection override
  // ------------------------------------------------------------------
  mgo_chan_t base_drv;    // generator, or all on when pwm disabled
  mgo_chan_t masked;      // channels under software mask
  mgo_chan_t mask_stage;  // after masking
  mgo_chan_t pre_dead;    // after override, into dead-time

  always_comb
  begin
    // disabled pwm holds every drive on; the guard then turns pairs off
    base_drv = pwm_out_enable ? pwm_gen_in : `MGO_ALL_ON;
    // software mask only in software mode and only on gate-function pins
    masked   = mask_mode_sel ? (q.mask_en & ~q.gpio) : `MGO_ALL_OFF;
    for (int k = 0; k < 6; k++)
    begin
      mask_stage[k] = masked[k] ? q.mask_val[k] : base_drv[k];
    end
    for (int p = 0; p < 6; p += 2)
    begin
      if (masked[p] && masked[p+1] && q.mask_val[p] && q.mask_val[p+1])
      begin
        // both halves masked on would short the leg
        mask_stage[p]   = 1'b0;
        mask_stage[p+1] = 1'b0;
      end
      else if (comp_pwm_en && (masked[p] != masked[p+1]))
      begin
        // the unmasked partner carries pwm; the masked one stays off
        if (masked[p])
        begin
          mask_stage[p] = 1'b0;
        end
        else
        begin
          mask_stage[p+1] = 1'b0;
        end
      end
    end
  end

  // brake above protection above everything else
  always_comb
  begin
    if (brake_ctrl)
    begin
      pre_dead = `MGO_LOW_SIDES;
    end
    else if (protect_on)
    begin
      pre_dead = protect_mode_sel ? `MGO_LOW_SIDES : `MGO_ALL_OFF;
    end
    else
    begin
      pre_dead = mask_stage;
    end
  end

  // ------------------------------------------------------------------
  // stage 2: dead-time clock and per-channel insertion
  // ------------------------------------------------------------------
  logic [2:0] div_mask; // prescaler bits that must all be set
  logic       dt_tick;  // one pulse per dead clock period
  mgo_chan_t  dead_out;

  // shared free-running prescaler: the first tick after a rise may come
  // early by up to one dead clock period less one system clock
  always_comb
  begin
    unique case (dead_clk_sel)
      MGO_DT_DIV1: div_mask = 3'h0;
      MGO_DT_DIV2: div_mask = 3'h1;
      MGO_DT_DIV4: div_mask = 3'h3;
      MGO_DT_DIV8: div_mask = 3'h7;
    endcase
  end
  assign dt_tick = ((q.presc & div_mask) == div_mask);

  for (genvar k = 0; k < 6; k++)
  begin : g_dead
    mgo_dead_chan #(
      .CW (DT_CW)
    ) u_dead (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .din     (pre_dead[k]),
      .tick    (dt_tick),
      .dt_en   (dead_time_enable),
      .dt_val  (dead_count_val),
      .dout    (dead_out[k])
    );
  end

  // ------------------------------------------------------------------
  // stage 3: staggered guard, drive 1 means transistor on
  // ------------------------------------------------------------------
  mgo_chan_t guarded;

  always_comb
  begin
    guarded = dead_out;
    for (int p = 0; p < 6; p += 2)
    begin
      if (dead_out[p] && dead_out[p+1])
      begin
        guarded[p]   = 1'b0;
        guarded[p+1] = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // register writes, read mux, pins, hall source
  // ------------------------------------------------------------------
  mgo_byte_t rd_mux;

  always_comb
  begin
    // unmapped and upper channel bits read as zero
    unique case (reg_addr)
      `MGO_ADDR_MASK_EN:   rd_mux = {2'h0, q.mask_en};
      `MGO_ADDR_MASK_VAL:  rd_mux = {2'h0, q.mask_val};
      `MGO_ADDR_DEAD:      rd_mux = q.dead_time_setup;
      `MGO_ADDR_POL:       rd_mux = {2'h0, q.pol};
      `MGO_ADDR_CTRL:      rd_mux = {1'h0, q.ctrl};
      `MGO_ADDR_HALL:      rd_mux = {3'h0, q.hall_cfg};
      `MGO_ADDR_PINFUNC:   rd_mux = {2'h0, q.gpio};
      `MGO_ADDR_DRV_STAT:  rd_mux = {2'h0, q.drv};
      `MGO_ADDR_HALL_STAT: rd_mux = {5'h00, q.hall};
      default:             rd_mux = `MGO_RST_BYTE;
    endcase
  end

  always_comb
  begin
    d = q;
    // software writes, one register per address
    if (reg_wr)
    begin
      unique case (reg_addr)
        `MGO_ADDR_MASK_EN:  d.mask_en  = reg_wdata[5:0];
        `MGO_ADDR_MASK_VAL: d.mask_val = reg_wdata[5:0];
        `MGO_ADDR_DEAD:     d.dead_time_setup      = reg_wdata;
        `MGO_ADDR_POL:      d.pol      = reg_wdata[5:0];
        `MGO_ADDR_CTRL:     d.ctrl     = reg_wdata[6:0];
        `MGO_ADDR_HALL:     d.hall_cfg = reg_wdata[4:0];
        `MGO_ADDR_PINFUNC:  d.gpio     = reg_wdata[5:0];
        default:            d.presc    = q.presc; // status and holes ignore writes
      endcase
    end
    d.rdata = reg_rd ? rd_mux : `MGO_RST_BYTE;
    d.presc = q.presc + 3'h1;
    // hall pins: three stages, a level counts once stages two and three agree
    d.hs1 = {hall_alt_in, hall_pin_in};
    d.hs2 = q.hs1;
    d.hs3 = q.hs2;
    for (int k = 0; k < 6; k++)
    begin
      if (q.hs2[k] == q.hs3[k])
      begin
        d.hst[k] = q.hs3[k];
      end
    end
    if (!hall_src_mode)
    begin
      d.hall = hall_decoder_data;
    end
    else
    begin
      d.hall = hall_sel ? q.hst[5:3] : q.hst[2:0];
    end
    // pins: inversion last, driven only when enabled and not general I/O
    d.drv = guarded;
    d.pin = guarded ^ q.pol;
    d.oe  = gate_out_en ? ~q.gpio : `MGO_ALL_OFF;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // pins stay undriven until software enables them
      q          <= '0;
      q.mask_en  <= `MGO_RST_CHAN;
      q.mask_val <= `MGO_RST_CHAN;
      q.dead_time_setup      <= `MGO_RST_BYTE;
      q.ctrl     <= `MGO_RST_CTRL;
      q.hall_cfg <= `MGO_RST_HALL;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata      = q.rdata;
  assign hall_dec_out   = q.hall;
  assign gate_a_high    = q.pin[0];
  assign gate_a_low     = q.pin[1];
  assign gate_b_high    = q.pin[2];
  assign gate_b_low     = q.pin[3];
  assign gate_c_high    = q.pin[4];
  assign gate_c_low     = q.pin[5];
  assign gate_a_high_oe = q.oe[0];
  assign gate_a_low_oe  = q.oe[1];
  assign gate_b_high_oe = q.oe[2];
  assign gate_b_low_oe  = q.oe[3];
  assign gate_c_high_oe = q.oe[4];
  assign gate_c_low_oe  = q.oe[5];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_brake_held;
    brake_ctrl [*3];
  endsequence
  sequence s_free_held;
    (protect_on && !protect_mode_sel && !brake_ctrl) [*3];
  endsequence
  sequence s_fast_rise;
    dead_time_enable && dead_clk_sel == MGO_DT_DIV1 && dead_count_val == '0
      && $rose(pre_dead[0]);
  endsequence

  AST_BRAKE_HIGHS_OFF: assert property (s_brake_held |-> (q.drv & `MGO_HIGH_SIDES) == '0)
    else $error("brake held but a high side is on");
  AST_PROTECT_FREE: assert property (s_free_held |-> q.drv == `MGO_ALL_OFF)
    else $error("free-run protection left a drive on");
  AST_GUARD_PAIRS: assert property ((q.drv & (q.drv >> 1) & `MGO_HIGH_SIDES) == '0)
    else $error("both sides of a pair driven on");
  AST_PAIR_BOTH_ONES: assert property (masked[1:0] == 2'h3 && q.mask_val[1:0] == 2'h3 |-> mask_stage[1:0] == 2'h0)
    else $error("pair masked high not forced low");
  AST_FALL_AT_ONCE: assert property (!pre_dead[2] |=> !dead_out[2])
    else $error("falling drive was delayed");
  AST_DEAD_OFF_PASS: assert property (!dead_time_enable && pre_dead[1] |=> dead_out[1])
    else $error("rise delayed with dead time off");
  AST_RISE_DELAY: assert property (s_fast_rise ##1 pre_dead[0] |-> !dead_out[0] ##1 dead_out[0])
    else $error("dead time of one period not inserted");
  AST_POLARITY: assert property (q.pin == (q.drv ^ $past(q.pol)))
    else $error("pin level does not follow polarity");
  AST_OE_NEEDS_ENABLE: assert property (q.oe != '0 |-> $past(gate_out_en))
    else $error("gate pin driven without enable");
  AST_HALL_SOFT: assert property (!hall_src_mode [*2] |-> q.hall == $past(hall_decoder_data))
    else $error("decoder not fed from software hall values");
endmodule
`default_nettype wire

// ---- verification/mgo_bridge_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// external half-bridge transistors behind the six gate pins
// ----------------------------------------------------------------------
module mgo_bridge_model (
  input  wire logic [5:0] pin,        // gate pin levels, bit0 a_high
  input  wire logic [5:0] pin_oe,     // high while the stage drives the pin
  input  wire logic [5:0] act_low,    // transistor switches on at a low level
  output logic      [5:0] on_bits,    // transistor conducting
  output logic            short_flag  // both sides of a pair conducting
);
  // an undriven pin floats and the gate pull-down keeps the transistor off
  always_comb
  begin
    on_bits    = (pin ^ act_low) & pin_oe;
    short_flag = |(on_bits & (on_bits >> 1) & 6'h15);
  end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mgo_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------------
  logic      clk_sys = 1'b0;
  logic      rst_b   = 1'b0;
  mgo_addr_t reg_addr = 4'h0;
  mgo_byte_t reg_wdata = 8'h00;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  mgo_byte_t reg_rdata;
  mgo_chan_t pwm_gen_in = 6'h00;
  mgo_hall_t hall_pin_in = 3'h6;
  mgo_hall_t hall_alt_in = 3'h3;
  mgo_hall_t hall_dec_out;
  wire  [5:0] pins;         // gate pin levels, one output port per bit
  wire  [5:0] oes;          // pin output enables, one output port per bit
  logic [5:0] pol;          // polarity the transistors are wired for
  logic [5:0] on_bits;
  logic       short_flag;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cyc        = 0;
  logic [47:0] rows [12];   // ctrl, mask en, mask val, polarity, drive, pins
  logic [7:0]  d;

  always #2.5 clk_sys = ~clk_sys;

  mgo_gate_stage #(.DT_CW(5)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_gen_in(pwm_gen_in),
    .hall_pin_in(hall_pin_in), .hall_alt_in(hall_alt_in), .hall_dec_out(hall_dec_out),
    .gate_a_high(pins[0]), .gate_a_low(pins[1]), .gate_b_high(pins[2]),
    .gate_b_low(pins[3]), .gate_c_high(pins[4]), .gate_c_low(pins[5]),
    .gate_a_high_oe(oes[0]), .gate_a_low_oe(oes[1]), .gate_b_high_oe(oes[2]),
    .gate_b_low_oe(oes[3]), .gate_c_high_oe(oes[4]), .gate_c_low_oe(oes[5]));

  mgo_bridge_model u_bridge (
    .pin(pins), .pin_oe(oes), .act_low(pol), .on_bits(on_bits), .short_flag(short_flag));

  // ----------------------------------------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------------------------------------
  task wr(input mgo_addr_t a, input mgo_byte_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input mgo_addr_t a, output mgo_byte_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // latency of a pin edge, bounded by a window of cycles
  task chk_lat(input logic [5:0] v, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk_sys);
    pwm_gen_in <= v;
    do
    begin
      @(posedge clk_sys);
      n++;
      #1;
    end
    while (pins !== v && n < 400);
    tests_run++;
    if (n < lo || n > hi)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    pol = 6'h00;
    rows = '{48'h50_00_00_00_01_01, 48'h50_00_00_00_03_00, 48'h58_03_01_00_02_01,
             48'h58_03_03_00_00_00, 48'h50_3F_01_00_04_04, 48'h51_00_00_00_15_2A,
             48'h52_00_00_00_15_00, 48'h56_00_00_00_15_2A, 48'h50_00_00_3F_01_3E,
             48'h40_00_00_00_15_00, 48'h78_02_02_00_01_01, 48'h59_2A_15_00_00_2A};
    repeat (3) @(posedge clk_sys);
    #1 chk8({2'b00, pins}, 8'h00);
    chk8({2'b00, oes}, 8'h00);
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int a = 0; a < 7; a++)
    begin
      rd(a[3:0], d);
      chk8(d, 8'h00);
    end
    // upper bits of the mask and polarity registers never stick
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    wr(4'h3, 8'hFF);
    rd(4'h0, d);
    chk8(d, 8'h3F);
    rd(4'h1, d);
    chk8(d, 8'h3F);
    rd(4'h3, d);
    chk8(d, 8'h3F);
    rd(4'hF, d);
    chk8(d, 8'h00);
    // table of output-chain cases, dead time off
    foreach (rows[i])
    begin
      wr(4'h4, rows[i][47:40]);
      wr(4'h0, rows[i][39:32]);
      wr(4'h1, rows[i][31:24]);
      wr(4'h3, rows[i][23:16]);
      pol = rows[i][21:16];
      pwm_gen_in <= rows[i][13:8];
      repeat (6) @(posedge clk_sys);
      #1 chk8({2'b00, pins}, rows[i][7:0]);
      chk8({2'b00, oes}, 8'h3F);
      chk8({7'h00, short_flag}, 8'h00);
    end
    // a pin in I/O use ignores the mask and is not driven
    wr(4'h6, 8'h01);
    wr(4'h4, 8'h58);
    wr(4'h0, 8'h01);
    // mask data low, so an applied mask would pull the drive off
    wr(4'h1, 8'h00);
    pwm_gen_in <= 6'h01;
    repeat (6) @(posedge clk_sys);
    #1 chk8({2'b00, oes}, 8'h3E);
    rd(4'h7, d);
    chk8(d, 8'h01);
    wr(4'h6, 8'h00);
    wr(4'h4, 8'h50);
    pwm_gen_in <= 6'h00;
    repeat (6) @(posedge clk_sys);
    // dead time of count 3 on each clock choice: rises late, falls at once
    for (int s = 0; s < 4; s++)
    begin
      wr(4'h2, {s[1:0], 1'b1, 5'h03});
      chk_lat(6'h01, 3 * (1 << s) + 3, 4 * (1 << s) + 2);
      chk_lat(6'h00, 2, 2);
    end
    // shortest dead time: one system clock before the rise shows
    wr(4'h2, 8'h20);
    chk_lat(6'h01, 3, 3);
    chk_lat(6'h00, 2, 2);
    // a dead time inside the range software must keep: 8 clocks of /8, at most 64 system clocks
    wr(4'h2, 8'hE7);
    chk_lat(6'h04, 59, 66);
    chk_lat(6'h00, 2, 2);
    wr(4'h2, 8'h03);
    chk_lat(6'h02, 2, 2);
    chk_lat(6'h00, 2, 2);
    // hall source selection
    wr(4'h5, 8'h05);
    repeat (10) @(posedge clk_sys);
    #1 chk8({5'h00, hall_dec_out}, 8'h05);
    wr(4'h5, 8'h08);
    repeat (10) @(posedge clk_sys);
    #1 chk8({5'h00, hall_dec_out}, 8'h06);
    wr(4'h5, 8'h18);
    repeat (10) @(posedge clk_sys);
    #1 chk8({5'h00, hall_dec_out}, 8'h03);
    conclude();
  end
endmodule
`default_nettype wire
